// >>> hw/eep_pkg.sv
package eep_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int ARRAY_BYTES = 512;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int BLOCK_LSB = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int OP_TIME_NS = 10000000;
    localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 21;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        EEP_ERS_BYTE = 2'h0,
        EEP_ERS_BLOCK = 2'h1,
        EEP_ERS_BULK = 2'h2
    } eep_ers_size_t;

    typedef enum logic [1:0]
    {
        EEP_IDLE = 2'h0,
        EEP_ACTIVE = 2'h1,
        EEP_COMMIT = 2'h3
    } eep_state_t;

    typedef struct packed
    {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } eep_req_t;

    typedef struct packed
    {
        logic erase;
        eep_ers_size_t size;
        logic auto_mode;
        logic pve_set;
        logic pve_clear;
    } eep_ctl_t;

    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic erase;
        eep_ers_size_t size;
    } eep_op_t;

endpackage

// >>> hw/eep_op_timer.sv
`timescale 1ns/1ps
`default_nettype none
module eep_op_timer #(
    parameter logic [eep_pkg::TIMER_W-1:0] CYCLES = eep_pkg::TIMER_W'(eep_pkg::OP_CYCLES)
)(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic start_in,
    input wire logic abort_in,
    output logic done_out
);
    logic [eep_pkg::TIMER_W-1:0] count_reg;
    logic [eep_pkg::TIMER_W-1:0] count_next;
    logic run_reg;
    logic run_next;

    // ------------------------------------------------------------
    // Countdown
    // ------------------------------------------------------------
    always_comb
    begin
        count_next = count_reg;
        run_next = run_reg;
        if (start_in)
        begin
            count_next = CYCLES;
            run_next = 1'b1;
        end
        else if (abort_in)
        begin
            run_next = 1'b0;
        end
        else if (run_reg)
        begin
            if (count_reg <= eep_pkg::TIMER_W'(1))
            begin
                run_next = 1'b0;
            end
            count_next = count_reg - eep_pkg::TIMER_W'(1);
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            count_reg <= '0;
            run_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            run_reg <= run_next;
        end
    end

    // Done must not depend on abort: the caller derives abort from done
    assign done_out = run_reg && (count_reg <= eep_pkg::TIMER_W'(1));
endmodule
`default_nettype wire

// >>> hw/eep_array_ctl.sv
// What this block does
// - One 512-byte array, own address window
// - Erased cells read back as one
// - Programming only clears bits to zero
// - Zero bits of write data get programmed
// - Erase sets byte, block or whole array
// - Single-bit writes accumulate zeros in byte
// - Self-timed mode ends operation, clears enable
`timescale 1ns/1ps
`default_nettype none
module eep_array_ctl #(
    parameter logic [eep_pkg::TIMER_W-1:0] OP_CYCLES = eep_pkg::TIMER_W'(eep_pkg::OP_CYCLES)
)(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire eep_pkg::eep_req_t req_in,
    input wire eep_pkg::eep_ctl_t ctl_in,
    output logic [eep_pkg::DATA_W-1:0] rdata_out,
    output logic rvalid_out,
    output logic program_voltage_enable_out,
    output logic busy_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [eep_pkg::DATA_W-1:0] mem [eep_pkg::ARRAY_BYTES] = '{default: eep_pkg::ERASED_BYTE};
    eep_pkg::eep_state_t state_reg;
    eep_pkg::eep_state_t state_next;
    eep_pkg::eep_op_t op_reg;
    eep_pkg::eep_op_t op_next;
    logic pve_reg;
    logic pve_next;
    logic auto_reg;
    logic auto_next;
    logic [eep_pkg::DATA_W-1:0] rdata_reg;
    logic [eep_pkg::DATA_W-1:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic timer_start;
    logic timer_abort;
    logic timer_done;
    logic [eep_pkg::DATA_W-1:0] sel_byte;

    function automatic logic in_erase_range(
        input logic [eep_pkg::ADDR_W-1:0] idx,
        input logic [eep_pkg::ADDR_W-1:0] base,
        input eep_pkg::eep_ers_size_t size
    );
        logic hit;
        hit = 1'b0;
        case (size)
            eep_pkg::EEP_ERS_BYTE: hit = (idx == base);
            eep_pkg::EEP_ERS_BLOCK:
                hit = (idx[eep_pkg::ADDR_W-1:eep_pkg::BLOCK_LSB]
                    == base[eep_pkg::ADDR_W-1:eep_pkg::BLOCK_LSB]);
            eep_pkg::EEP_ERS_BULK: hit = 1'b1;
            default: hit = (idx == base);
        endcase
        return hit;
    endfunction

    assign sel_byte = mem[op_reg.addr];

    eep_op_timer #(
        .CYCLES(OP_CYCLES)
    ) u_timer (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .start_in(timer_start),
        .abort_in(timer_abort),
        .done_out(timer_done)
    );

    // ------------------------------------------------------------
    // Control sequence
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        op_next = op_reg;
        pve_next = pve_reg;
        auto_next = auto_reg;
        timer_start = 1'b0;
        timer_abort = 1'b0;
        rvalid_next = req_in.valid && !req_in.write;
        rdata_next = rdata_reg;
        if (req_in.valid && !req_in.write)
        begin
            rdata_next = mem[req_in.addr];
        end
        case (state_reg)
            eep_pkg::EEP_IDLE:
            begin
                if (req_in.valid && req_in.write)
                begin
                    op_next.addr = req_in.addr;
                    op_next.data = req_in.data;
                end
                if (ctl_in.pve_set)
                begin
                    op_next.erase = ctl_in.erase;
                    op_next.size = ctl_in.size;
                    auto_next = ctl_in.auto_mode;
                    pve_next = 1'b1;
                    timer_start = ctl_in.auto_mode;
                    state_next = eep_pkg::EEP_ACTIVE;
                end
            end
            eep_pkg::EEP_ACTIVE:
            begin
                if (auto_reg && timer_done)
                begin
                    pve_next = 1'b0;
                    state_next = eep_pkg::EEP_COMMIT;
                end
                else if (ctl_in.pve_clear)
                begin
                    timer_abort = 1'b1;
                    pve_next = 1'b0;
                    state_next = eep_pkg::EEP_COMMIT;
                end
            end
            eep_pkg::EEP_COMMIT:
            begin
                state_next = eep_pkg::EEP_IDLE;
            end
            default:
            begin
                state_next = eep_pkg::EEP_IDLE;
                pve_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_reg <= eep_pkg::EEP_IDLE;
            op_reg <= '0;
            pve_reg <= 1'b0;
            auto_reg <= 1'b0;
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            op_reg <= op_next;
            pve_reg <= pve_next;
            auto_reg <= auto_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ------------------------------------------------------------
    // Array update
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (state_reg == eep_pkg::EEP_COMMIT)
        begin
            for (int i = 0; i < eep_pkg::ARRAY_BYTES; i++)
            begin
                if (op_reg.erase)
                begin
                    if (in_erase_range(eep_pkg::ADDR_W'(i), op_reg.addr, op_reg.size))
                    begin
                        mem[i] <= eep_pkg::ERASED_BYTE;
                    end
                end
                else if (eep_pkg::ADDR_W'(i) == op_reg.addr)
                begin
                    mem[i] <= mem[i] & op_reg.data;
                end
            end
        end
    end

    assign rdata_out = rdata_reg;
    assign rvalid_out = rvalid_reg;
    assign program_voltage_enable_out = pve_reg;
    assign busy_out = (state_reg != eep_pkg::EEP_IDLE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);

    property p_read_back;
        (req_in.valid && !req_in.write && state_reg != eep_pkg::EEP_COMMIT)
            |=> rvalid_out && rdata_out == mem[$past(req_in.addr)];
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data mismatch");

    property p_bulk_all_ones;
        (state_reg == eep_pkg::EEP_COMMIT && op_reg.erase && op_reg.size == eep_pkg::EEP_ERS_BULK)
            |=> mem[0] == 8'hFF && mem[eep_pkg::ARRAY_BYTES-1] == 8'hFF;
    endproperty
    a_bulk_all_ones: assert property (p_bulk_all_ones) else $error("bulk erase left zeros");

    property p_no_rise;
        (state_reg == eep_pkg::EEP_COMMIT && !op_reg.erase)
            |=> (mem[$past(op_reg.addr)] & ~$past(sel_byte)) == 8'h00;
    endproperty
    a_no_rise: assert property (p_no_rise) else $error("program raised a bit");

    property p_prog_and;
        (state_reg == eep_pkg::EEP_COMMIT && !op_reg.erase)
            |=> mem[$past(op_reg.addr)] == ($past(sel_byte) & $past(op_reg.data));
    endproperty
    a_prog_and: assert property (p_prog_and) else $error("program result wrong");

    property p_erase_byte;
        (state_reg == eep_pkg::EEP_COMMIT && op_reg.erase) |=> mem[$past(op_reg.addr)] == 8'hFF;
    endproperty
    a_erase_byte: assert property (p_erase_byte) else $error("erase left zeros");

    property p_accumulate;
        (state_reg == eep_pkg::EEP_COMMIT && !op_reg.erase)
            |=> $countones(mem[$past(op_reg.addr)]) <= $countones($past(sel_byte));
    endproperty
    a_accumulate: assert property (p_accumulate) else $error("zeros not accumulated");

    property p_auto_end;
        (state_reg == eep_pkg::EEP_ACTIVE && auto_reg && timer_done)
            |=> !program_voltage_enable_out ##1 !busy_out;
    endproperty
    a_auto_end: assert property (p_auto_end) else $error("self-timed end missing");

    property p_manual_end;
        (state_reg == eep_pkg::EEP_ACTIVE && !auto_reg && ctl_in.pve_clear)
            |=> state_reg == eep_pkg::EEP_COMMIT && !program_voltage_enable_out;
    endproperty
    a_manual_end: assert property (p_manual_end) else $error("manual end missing");

    c_auto_prog: cover property (state_reg == eep_pkg::EEP_COMMIT && auto_reg && !op_reg.erase);
    c_bulk: cover property (state_reg == eep_pkg::EEP_COMMIT && op_reg.size == eep_pkg::EEP_ERS_BULK);
    c_manual: cover property (state_reg == eep_pkg::EEP_ACTIVE && ctl_in.pve_clear);
endmodule
`default_nettype wire

// >>> test/eep_array_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eep_array_ctl_tb;
    localparam int OPC = 5;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    eep_pkg::eep_req_t req = '0;
    eep_pkg::eep_ctl_t ctl = '0;
    logic [7:0] rdata;
    logic rvalid;
    logic pve;
    logic busy;
    logic [7:0] mem [512];
    int error_cnt = 0;
    int num_checks = 0;

    always #4 mclk_in = ~mclk_in;

    eep_array_ctl #(
        .OP_CYCLES(eep_pkg::TIMER_W'(OPC))
    ) u_dut (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .req_in(req),
        .ctl_in(ctl),
        .rdata_out(rdata),
        .rvalid_out(rvalid),
        .program_voltage_enable_out(pve),
        .busy_out(busy)
    );

    // ------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] prog(logic [7:0] old, logic [7:0] d);
        return old & d;
    endfunction

    function automatic logic hit(int a, int base, int sz);
        if (sz == 0)
            return a == base;
        if (sz == 1)
            return (a >> eep_pkg::BLOCK_LSB) == (base >> eep_pkg::BLOCK_LSB);
        return 1'b1;
    endfunction

    // ------------------------------------------------------------
    // Driver and compare tasks
    // ------------------------------------------------------------
    task automatic tick;
        @(posedge mclk_in);
        #1;
    endtask

    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(int a);
        req = '{valid: 1'b1, write: 1'b0, addr: 9'(a), data: 8'h00};
        tick;
        req.valid = 1'b0;
        check("read valid", 8'h01, {7'h00, rvalid});
        check("read data", mem[a], rdata);
        tick;
        check("read valid drop", 8'h00, {7'h00, rvalid});
    endtask

    task automatic verify_all;
        for (int a = 0; a < 512; a++)
            rd(a);
    endtask

    task automatic op(int a, logic [7:0] d, logic er, int sz, logic au);
        int n;
        req = '{valid: 1'b1, write: 1'b1, addr: 9'(a), data: d};
        tick;
        req.valid = 1'b0;
        ctl.erase = er;
        ctl.size = eep_pkg::eep_ers_size_t'(sz);
        ctl.auto_mode = au;
        ctl.pve_set = 1'b1;
        tick;
        ctl.pve_set = 1'b0;
        check("enable rise", 8'h01, {7'h00, pve});
        check("busy rise", 8'h01, {7'h00, busy});
        req = '{valid: 1'b1, write: 1'b1, addr: 9'(a ^ 1), data: 8'h00};
        tick;
        req.valid = 1'b0;
        n = 1;
        if (au)
        begin
            while (pve === 1'b1 && n < 50)
            begin
                tick;
                n++;
            end
            check("self timed length", 8'(OPC), 8'(n));
        end
        else
        begin
            ctl.pve_clear = 1'b1;
            tick;
            ctl.pve_clear = 1'b0;
            check("enable cleared", 8'h00, {7'h00, pve});
        end
        check("busy in commit", 8'h01, {7'h00, busy});
        tick;
        check("busy end", 8'h00, {7'h00, busy});
        for (int i = 0; i < 512; i++)
        begin
            if (er && hit(i, a, sz))
                mem[i] = 8'hFF;
            else if (!er && i == a)
                mem[i] = prog(mem[i], d);
        end
    endtask

    // Self-timed program cut short by software, then a start while busy
    task automatic op_cut(int a, logic [7:0] d);
        req = '{valid: 1'b1, write: 1'b1, addr: 9'(a), data: d};
        ctl = '{erase: 1'b0, size: eep_pkg::EEP_ERS_BYTE, auto_mode: 1'b1,
            pve_set: 1'b1, pve_clear: 1'b0};
        tick;
        req.valid = 1'b0;
        ctl.pve_set = 1'b0;
        ctl.pve_clear = 1'b1;
        tick;
        check("enable cut early", 8'h00, {7'h00, pve});
        check("busy after cut", 8'h01, {7'h00, busy});
        ctl = '{erase: 1'b1, size: eep_pkg::EEP_ERS_BULK, auto_mode: 1'b0,
            pve_set: 1'b1, pve_clear: 1'b0};
        tick;
        ctl.pve_set = 1'b0;
        check("start while busy", 8'h00, {6'h00, pve, busy});
        mem[a] = prog(mem[a], d);
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        int a;
        void'($urandom(23));
        foreach (mem[i])
            mem[i] = 8'hFF;
        repeat (20) tick;
        check("reset outputs", 8'h00, {5'h00, pve, busy, rvalid});
        check("reset rdata", 8'h00, rdata);
        reset_in = 1'b0;
        tick;
        verify_all;
        for (int k = 0; k < 24; k++)
        begin
            a = ($urandom % 4) * 37;
            op(a, ~(mem[a] & 8'($urandom)), 1'b0, 0, k[0]);
            rd(a);
        end
        op_cut(37, ~(mem[37] & 8'($urandom)));
        rd(37);
        op(511, 8'h00, 1'b1, 0, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            op(511, ~(8'h01 << i), 1'b0, 0, 1'b1);
            rd(511);
            check("selective bits", 8'hFF << (i + 1), rdata);
        end
        for (int s = 0; s < 3; s++)
        begin
            for (int j = 0; j < 512; j += 7)
                op(j, ~(mem[j] & 8'($urandom)), 1'b0, 0, 1'b1);
            op($urandom % 512, 8'h00, 1'b1, s, s[0]);
            verify_all;
        end
        // Mid-run reset: outputs clear, array contents survive
        reset_in = 1'b1;
        tick;
        check("reset mid run", 8'h00, {5'h00, pve, busy, rvalid});
        reset_in = 1'b0;
        tick;
        rd(511);
        rd(37);
        final_report;
    end

    initial
    begin
        #200000;
        error_cnt++;
        $display("wrong value watchdog expected done seen timeout");
        final_report;
    end
endmodule
`default_nettype wire
